// >>> design/sip_pkg.sv
// package: register map, fields, reset values and carrier types of the instruction prefetch block
package sip_pkg;
   // register byte offsets
   localparam logic [7:0] SIP_INSTR_PTR_OFF = 8'h2c;
   localparam logic [7:0] SIP_DMA_MODE_OFF  = 8'h38;
   localparam logic [7:0] SIP_DMA_CTRL_OFF  = 8'h3c;
   localparam logic [7:0] SIP_STATUS_OFF    = 8'h40;
   // field positions
   localparam int SIP_MODE_BL_LSB   = 6;   // burst length code, two bits
   localparam int SIP_MODE_BOF_BIT  = 1;   // burst opcode fetch enable
   localparam int SIP_CTRL_PFF_BIT  = 6;   // prefetch flush, self clearing
   localparam int SIP_CTRL_PFEN_BIT = 5;   // prefetch enable
   // reset values
   localparam logic [7:0]  SIP_MODE_RST  = 8'h00;
   localparam logic [7:0]  SIP_CTRL_RST  = 8'h00;
   localparam logic [31:0] SIP_IP_RST    = 32'h0000_0000;
   // prefetch geometry and bus constants
   localparam int          SIP_PF_WORDS     = 8;
   localparam logic [4:0]  SIP_PF_MIN_BURST = 5'h04;
   localparam logic [3:0]  SIP_CMD_MEM_READ = 4'h6;
   localparam logic [1:0]  SIP_RESP_OKAY    = 2'b00;
   localparam logic [1:0]  SIP_RESP_SLVERR  = 2'b10;

   // instruction kinds that shape burst opcode fetch
   typedef enum logic [1:0] {
      SIP_K_PLAIN    = 2'b00,
      SIP_K_MOVE     = 2'b01,
      SIP_K_INDIRECT = 2'b10,
      SIP_K_TBLMOVE  = 2'b11
   } sip_kind_t;

   // engine fetch request
   typedef struct packed {
      logic [31:0] addr;
      sip_kind_t   kind;
      logic [2:0]  nwords;
   } sip_ins_t;

   // engine events that may flush the buffer
   typedef struct packed {
      logic move;
      logic store;
      logic no_flush;
      logic branch_taken;
   } sip_ev_t;

   // memory read request, one per bus ownership
   typedef struct packed {
      logic [31:0] addr;
      logic [4:0]  len;
      logic [3:0]  cmd;
   } sip_mreq_t;

   // fetch state machine, gray from IDLE through PICK and MREQ to MDATA
   typedef enum logic [2:0] {
      SIP_IDLE  = 3'b000,
      SIP_PICK  = 3'b001,
      SIP_MREQ  = 3'b011,
      SIP_MDATA = 3'b010,
      SIP_RAMRD = 3'b110,
      SIP_PUSH  = 3'b111
   } sip_state_t;

   // burst length code to words
   function automatic logic [4:0] sip_burst_words(input logic [1:0] code);
      sip_burst_words = 5'h02 << code;
   endfunction
endpackage

// >>> design/sip_prefetch.sv
// instruction prefetch front end with its output word fifo
module sip_fifo #(
   parameter int W = 32,
   parameter int D = 4
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } sip_fifo_st_t;
   sip_fifo_st_t s_q, s_d;
   logic push, pop;

   assign in_ready  = (s_q.cnt != (AW+1)'(D));
   assign out_valid = (s_q.cnt != '0);
   assign out_data  = s_q.mem[s_q.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // pointers wrap at depth, count tracks occupancy honestly
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp = (s_q.wp == AW'(D-1)) ? '0 : s_q.wp + 1'b1;
      end
      if (pop) begin
         s_d.rp = (s_q.rp == AW'(D-1)) ? '0 : s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// What this block does
// - prefetch enable fills an eight dword buffer
// - prefetch burst limited by programmed burst length
// - bursts under four dwords disable prefetching
// - prefetch uses plain memory read only
// - memory move flushes unless no-flush set
// - store flushes unless no-flush set
// - instruction pointer write flushes buffer
// - taken transfer of control flushes buffer
// - control bit 6 flushes, then self clears
// - burst opcode fetch reads two longwords together
// - memory move third longword separately owned
// - indirect extra longword in later ownership
// - table indirect move: two bursts of two
// - internal ram fetches skip the bus
module sip_prefetch
   import sip_pkg::*;
#(
   parameter int          PF_D     = SIP_PF_WORDS,
   parameter int          FIFO_D   = 4,
   parameter logic [31:0] RAM_BASE = 32'h0000_0000,
   parameter int          RAM_AW   = 12
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output      logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   input  wire logic        ins_valid,
   output      logic        ins_ready,
   input  wire sip_ins_t    ins,
   input  wire sip_ev_t     ev,
   output      logic        word_valid,
   input  wire logic        word_ready,
   output      logic [31:0] word_data,
   output      logic        ip_load,
   output      logic [31:0] ip_value,
   output      logic        mem_valid,
   input  wire logic        mem_ready,
   output      sip_mreq_t   mem_req,
   input  wire logic        mem_rvalid,
   output      logic        mem_rready,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        mem_rlast,
   output      logic        ram_en,
   output      logic [RAM_AW-3:0] ram_addr,
   input  wire logic [31:0] ram_rdata
);
   localparam int PAW = $clog2(PF_D);

   typedef struct packed {
      sip_state_t              st;
      sip_ins_t                req;
      logic [2:0]              w;
      logic [31:0]             addr;
      logic [7:0]              dma_mode_reg;
      logic [7:0]              dma_control_reg;
      logic [31:0]             ip;
      logic                    ip_load;
      logic [PF_D-1:0][31:0]   pf_mem;
      logic [31:0]             pf_base;
      logic [PAW:0]            pf_cnt;
      logic                    pf_fill;
      logic                    pf_stale;
      logic [31:0]             word;
      sip_mreq_t               mreq;
      logic                    aw_hold;
      logic [7:0]              aw_addr;
      logic                    w_hold;
      logic [31:0]             w_data;
      logic [3:0]              w_strb;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
   } sip_st_t;

   sip_st_t     s_q, s_d;
   logic        fifo_valid, fifo_ready;
   logic [31:0] fifo_data;
   logic [4:0]  burst;
   logic        pf_on, in_ram, hit, flush, do_wr;
   logic [31:0] off;
   logic [4:0]  seg_len, pf_len;

   // word fifo toward the execution engine; a full fifo stalls the fetch machine
   sip_fifo #(.W(32), .D(FIFO_D)) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (fifo_valid),
      .in_ready  (fifo_ready),
      .in_data   (fifo_data),
      .out_valid (word_valid),
      .out_ready (word_ready),
      .out_data  (word_data)
   );

   // bus and engine facing outputs
   assign s_axi_awready = !s_q.aw_hold && !s_q.bvalid;
   assign s_axi_wready  = !s_q.w_hold && !s_q.bvalid;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;
   assign ins_ready     = (s_q.st == SIP_IDLE);
   assign ip_load       = s_q.ip_load;
   assign ip_value      = s_q.ip;
   assign mem_valid     = (s_q.st == SIP_MREQ);
   assign mem_req       = s_q.mreq;
   assign ram_addr      = s_q.addr[RAM_AW-1:2];
   assign do_wr         = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;

   // mode decode
   // burst from mode
   assign burst  = sip_burst_words(s_q.dma_mode_reg[SIP_MODE_BL_LSB +: 2]);
   assign pf_len = (burst > 5'(PF_D)) ? 5'(PF_D) : burst;
   assign pf_on  = s_q.dma_control_reg[SIP_CTRL_PFEN_BIT] && (burst >= SIP_PF_MIN_BURST);
   assign in_ram = (s_q.addr[31:RAM_AW] == RAM_BASE[31:RAM_AW]);
   assign off    = s_q.addr - s_q.pf_base;
   assign hit    = (off[31:PAW+2] == '0) && ((PAW+1)'(off[PAW+1:2]) < s_q.pf_cnt) && (off[1:0] == 2'b00);

   // segment length for direct fetches
   always_comb begin
      seg_len = 5'h01;
      if (s_q.dma_mode_reg[SIP_MODE_BOF_BIT]) begin
         if (s_q.w == 3'h0 && s_q.req.nwords >= 3'h2) begin
            seg_len = 5'h02;
         end else if (s_q.req.kind == SIP_K_TBLMOVE && s_q.w == 3'h2 && s_q.req.nwords >= 3'h4) begin
            seg_len = 5'h02;
         end
      end
   end

   // flush sources, all engine events arrive on this clock
   always_comb begin
      flush = (ev.move || ev.store) && !ev.no_flush;
      flush = flush || ev.branch_taken;
      flush = flush || s_q.dma_control_reg[SIP_CTRL_PFF_BIT];
      flush = flush || (do_wr && s_q.aw_addr[7:2] == SIP_INSTR_PTR_OFF[7:2]);
   end

   // fetch machine, register file and bus slave in one next-state process
   always_comb begin
      s_d         = s_q;
      s_d.ip_load = 1'b0;
      fifo_valid  = 1'b0;
      fifo_data   = s_q.word;
      mem_rready  = 1'b0;
      ram_en      = 1'b0;
      case (s_q.st)
         SIP_IDLE: begin
            if (ins_valid) begin
               s_d.req  = ins;
               s_d.addr = ins.addr;
               s_d.w    = 3'h0;
               s_d.st   = SIP_PICK;
            end
         end
         SIP_PICK: begin
            if (s_q.w >= s_q.req.nwords) begin
               s_d.st = SIP_IDLE;
            end else if (in_ram) begin
               ram_en = 1'b1;
               s_d.st = SIP_RAMRD;
            end else if (pf_on && hit) begin
               s_d.word = s_q.pf_mem[off[PAW+1:2]];
               s_d.st   = SIP_PUSH;
            end else if (pf_on) begin
               s_d.pf_base  = s_q.addr;
               s_d.pf_cnt   = '0;
               s_d.pf_fill  = 1'b1;
               s_d.pf_stale = 1'b0;
               s_d.mreq = '{addr: s_q.addr, len: pf_len, cmd: SIP_CMD_MEM_READ};
               s_d.st   = SIP_MREQ;
            end else begin
               s_d.pf_fill = 1'b0;
               s_d.mreq    = '{addr: s_q.addr, len: seg_len, cmd: SIP_CMD_MEM_READ};
               s_d.st      = SIP_MREQ;
            end
         end
         SIP_MREQ: begin
            if (mem_ready) begin
               s_d.st = SIP_MDATA;
            end
         end
         SIP_MDATA: begin
            if (s_q.pf_fill) begin
               // buffer fill never stalls the memory side
               mem_rready = 1'b1;
               if (mem_rvalid) begin
                  s_d.pf_mem[s_q.pf_cnt[PAW-1:0]] = mem_rdata;
                  s_d.pf_cnt = s_q.pf_cnt + 1'b1;
               end
            end else begin
               // direct words stream straight into the fifo
               mem_rready = fifo_ready;
               fifo_valid = mem_rvalid;
               fifo_data  = mem_rdata;
               if (mem_rvalid && fifo_ready) begin
                  s_d.addr = s_q.addr + 32'h4;
                  s_d.w    = s_q.w + 3'h1;
               end
            end
            if (mem_rvalid && mem_rready && mem_rlast) begin
               s_d.st = SIP_PICK;
               if (s_q.pf_fill && s_q.pf_stale) begin
                  s_d.pf_cnt = '0;
               end
               s_d.pf_fill = 1'b0;
            end
         end
         SIP_RAMRD: begin
            s_d.word = ram_rdata;
            s_d.st   = SIP_PUSH;
         end
         SIP_PUSH: begin
            fifo_valid = 1'b1;
            if (fifo_ready) begin
               s_d.addr = s_q.addr + 32'h4;
               s_d.w    = s_q.w + 3'h1;
               s_d.st   = SIP_PICK;
            end
         end
         default: begin
            s_d.st = SIP_IDLE;
         end
      endcase

      // flush empties the buffer; a fill in flight is marked stale so its words are dropped
      if (flush) begin
         s_d.pf_cnt   = '0;
         s_d.pf_stale = s_q.pf_fill;
         if (s_q.pf_fill && s_q.st == SIP_PICK) begin
            s_d.pf_stale = 1'b0;
         end
      end
      s_d.dma_control_reg[SIP_CTRL_PFF_BIT] = 1'b0;

      // write address and data may come in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_hold = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_hold = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (do_wr) begin
         s_d.aw_hold = 1'b0;
         s_d.w_hold  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = SIP_RESP_OKAY;
         case (s_q.aw_addr[7:2])
            SIP_DMA_MODE_OFF[7:2]: begin
               if (s_q.w_strb[0]) s_d.dma_mode_reg = s_q.w_data[7:0];
            end
            SIP_DMA_CTRL_OFF[7:2]: begin
               if (s_q.w_strb[0]) s_d.dma_control_reg = s_q.w_data[7:0];
            end
            SIP_INSTR_PTR_OFF[7:2]: begin
               for (int b = 0; b < 4; b++) begin
                  if (s_q.w_strb[b]) s_d.ip[8*b +: 8] = s_q.w_data[8*b +: 8];
               end
               s_d.ip_load = 1'b1;
            end
            SIP_STATUS_OFF[7:2]: begin
               s_d.bresp = SIP_RESP_OKAY;  // read only, write ignored
            end
            default: begin
               s_d.bresp = SIP_RESP_SLVERR;
            end
         endcase
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end

      // reads answer one cycle after the address is taken
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = SIP_RESP_OKAY;
         case (s_axi_araddr[7:2])
            SIP_DMA_MODE_OFF[7:2]:  s_d.rdata = {24'h0, s_q.dma_mode_reg};
            SIP_DMA_CTRL_OFF[7:2]:  s_d.rdata = {24'h0, s_q.dma_control_reg};
            SIP_INSTR_PTR_OFF[7:2]: s_d.rdata = s_q.ip;
            SIP_STATUS_OFF[7:2]:    s_d.rdata = {16'h0, 3'h0, pf_on, 1'b0, s_q.st, 4'(s_q.pf_cnt), 4'h0};
            default: begin
               s_d.rdata = 32'h0;
               s_d.rresp = SIP_RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q                 <= '0;
         s_q.st              <= SIP_IDLE;
         s_q.dma_mode_reg    <= SIP_MODE_RST;
         s_q.dma_control_reg <= SIP_CTRL_RST;
         s_q.ip              <= SIP_IP_RST;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// >>> sim/sip_mem_model.sv
// memory side model: answers read requests with address derived data words
module sip_mem_model
   import sip_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        slow,
   input  wire logic        mem_valid,
   output      logic        mem_ready,
   input  wire sip_mreq_t   mem_req,
   output      logic        mem_rvalid,
   input  wire logic        mem_rready,
   output      logic [31:0] mem_rdata,
   output      logic        mem_rlast
);
   timeunit 1ns;
   timeprecision 100ps;
   sip_mreq_t   reqs[$];
   logic [31:0] a;
   logic [4:0]  left;
   logic [1:0]  dly;
   // one ownership at a time; idle data shows the inverse so stale words never match
   always @(posedge aclk) begin
      if (!aresetn) begin
         mem_ready  <= 1'b0;
         mem_rvalid <= 1'b0;
         mem_rlast  <= 1'b0;
         mem_rdata  <= 32'h0;
         left       <= 5'h00;
      end else begin
         if (mem_valid && mem_ready) begin
            mem_ready <= 1'b0;
            left      <= mem_req.len;
            a         <= mem_req.addr;
            dly       <= slow ? 2'h3 : 2'h0;
            reqs.push_back(mem_req);
         end else if (left == 5'h00 && !mem_rvalid) begin
            mem_ready <= mem_valid;
         end
         if (mem_rvalid && mem_rready) begin
            mem_rvalid <= 1'b0;
            mem_rlast  <= 1'b0;
            mem_rdata  <= ~mem_rdata;
            left       <= left - 5'h01;
            a          <= a + 32'h4;
         end else if (left != 5'h00 && !mem_rvalid) begin
            if (dly != 2'h0) begin
               dly <= dly - 2'h1;
            end else begin
               mem_rvalid <= 1'b1;
               mem_rdata  <= a ^ 32'h5a00_0000;
               mem_rlast  <= (left == 5'h01);
            end
         end
      end
   end
endmodule

// >>> sim/sip_assertions.sv
// checker: port level properties of the prefetch block
module sip_assertions
   import sip_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_awready,
   input wire logic        ins_valid,
   input wire logic        ins_ready,
   input wire logic        word_valid,
   input wire logic        word_ready,
   input wire logic [31:0] word_data,
   input wire logic        ip_load,
   input wire logic        mem_valid,
   input wire logic        mem_ready,
   input wire sip_mreq_t   mem_req,
   input wire logic        ram_en
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_CMD_READ:
   assert property (mem_valid |-> mem_req.cmd == SIP_CMD_MEM_READ) else $error("memory request not a plain read");
   AST_LEN_CAP:
   assert property (mem_valid |-> mem_req.len inside {[1:8]}) else $error("memory request length out of range");
   AST_MREQ_HOLD:
   assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_req)) else $error("memory request dropped");
   AST_RAM_NO_BUS:
   assert property (ram_en |-> !mem_valid) else $error("internal ram fetch used the bus");
   AST_W_REFUSE:
   assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken while response pending");
   AST_R_ONE:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   AST_IP_PULSE:
   assert property (ip_load |=> !ip_load) else $error("pointer load longer than one cycle");
   AST_INS_BUSY:
   assert property (ins_valid && ins_ready |=> !ins_ready) else $error("fetch request not refused while busy");
   AST_WORD_HOLD:
   assert property (word_valid && !word_ready |=> word_valid && $stable(word_data)) else $error("word changed while stalled");
endmodule

bind sip_prefetch sip_assertions i_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_bvalid, .s_axi_awready, .ins_valid, .ins_ready, .word_valid, .word_ready, .word_data, .ip_load,
   .mem_valid, .mem_ready, .mem_req, .ram_en);

// >>> sim/testbench.sv
// testbench: registers, direct and burst fetch, prefetch flushes, ram and fifo scenarios
module testbench
   import sip_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ins_valid, ins_ready;
   logic        word_valid, word_ready, ip_load, mem_valid, mem_ready, mem_rvalid, mem_rready, mem_rlast;
   logic        ram_en, slow;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, word_data, ip_value, mem_rdata, ram_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [9:0]  ram_addr;
   sip_ins_t    ins;
   sip_ev_t     ev;
   sip_mreq_t   mem_req;
   int          failures, n_compared;

   sip_prefetch i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .ins_valid,
      .ins_ready, .ins, .ev, .word_valid, .word_ready, .word_data, .ip_load, .ip_value, .mem_valid, .mem_ready,
      .mem_req, .mem_rvalid, .mem_rready, .mem_rdata, .mem_rlast, .ram_en, .ram_addr, .ram_rdata);
   sip_mem_model i_mem (.aclk, .aresetn, .slow, .mem_valid, .mem_ready, .mem_req, .mem_rvalid, .mem_rready,
      .mem_rdata, .mem_rlast);

   // clock at 40 MHz
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // internal ram answers one cycle after its strobe, inverse when idle
   always @(posedge aclk) ram_rdata <= (ram_en || !aresetn) ? {20'h0, ram_addr, 2'b00} ^ 32'h00c3_0000 : ~ram_rdata;

   function automatic logic [31:0] pat(input logic [31:0] a);
      return a ^ ((a[31:12] == 20'h0) ? 32'h00c3_0000 : 32'h5a00_0000);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // register bus master: both address and data offered together, response held ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int t;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      t = 0;
      do begin
         @(posedge aclk);
         t++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && t < 50);
      s_axi_bready <= 1'b0;
      chk({31'h0, s_axi_bvalid}, 32'h1);
      chk({30'h0, s_axi_bresp}, {30'h0, r});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int t;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      t = 0;
      do begin
         @(posedge aclk);
         t++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && t < 50);
      s_axi_rready <= 1'b0;
      chk({31'h0, s_axi_rvalid}, 32'h1);
      chk(s_axi_rdata, d);
      chk({30'h0, s_axi_rresp}, {30'h0, r});
   endtask
   // engine side: request held until taken, words drained in address order
   task automatic send(input logic [31:0] a, input sip_kind_t k, input logic [2:0] n);
      int t;
      @(posedge aclk);
      ins_valid <= 1'b1;
      ins <= {a, k, n};
      t = 0;
      do begin
         @(posedge aclk);
         t++;
      end while (ins_ready !== 1'b1 && t < 400);
      ins_valid <= 1'b0;
      chk({31'h0, ins_ready}, 32'h1);
   endtask
   task automatic get(input logic [31:0] a, input int n);
      int t;
      @(posedge aclk);
      word_ready <= 1'b1;
      for (int i = 0; i < n; i++) begin
         t = 0;
         do begin
            @(posedge aclk);
            t++;
         end while (word_valid !== 1'b1 && t < 400);
         chk({31'h0, word_valid}, 32'h1);
         chk(word_data, pat(a + 32'(4 * i)));
      end
      word_ready <= 1'b0;
   endtask
   task automatic fetch(input logic [31:0] a, input sip_kind_t k, input logic [2:0] n);
      send(a, k, n);
      get(a, int'(n));
   endtask
   task automatic ereq(input logic [31:0] a, input logic [4:0] l);
      sip_mreq_t r;
      r = '0;
      if (i_mem.reqs.size() != 0) r = i_mem.reqs.pop_front();
      chk(r.addr, a);
      chk({27'h0, r.len}, {27'h0, l});
   endtask
   task automatic enone;
      chk(32'(i_mem.reqs.size()), 32'h0);
   endtask
   task automatic evp(input logic [3:0] e);
      @(posedge aclk);
      ev <= e;
      @(posedge aclk);
      ev <= '0;
   endtask

   task automatic t_regs;
      rd(SIP_DMA_MODE_OFF, {24'h0, SIP_MODE_RST}, SIP_RESP_OKAY);
      rd(SIP_DMA_CTRL_OFF, {24'h0, SIP_CTRL_RST}, SIP_RESP_OKAY);
      rd(SIP_INSTR_PTR_OFF, SIP_IP_RST, SIP_RESP_OKAY);
      rd(8'h10, 32'h0, SIP_RESP_SLVERR);
      wr(8'h10, 32'hffff_ffff, SIP_RESP_SLVERR);
   endtask
   task automatic t_direct;
      slow <= 1'b1;
      fetch(32'h1_0000, SIP_K_PLAIN, 3'h3);
      for (int i = 0; i < 3; i++) ereq(32'h1_0000 + 32'(4 * i), 5'h01);
      slow <= 1'b0;
   endtask
   // opcode burst with prefetch left off
   task automatic t_bof;
      sip_kind_t ks[4] = '{SIP_K_PLAIN, SIP_K_MOVE, SIP_K_INDIRECT, SIP_K_TBLMOVE};
      wr(SIP_DMA_MODE_OFF, 32'h02, SIP_RESP_OKAY);
      rd(SIP_DMA_MODE_OFF, 32'h02, SIP_RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         fetch(32'h4_0000, ks[i], (i == 0) ? 3'h2 : (i == 3) ? 3'h4 : 3'h3);
         ereq(32'h4_0000, 5'h02);
         if (i != 0) ereq(32'h4_0008, (i == 3) ? 5'h02 : 5'h01);
      end
      enone();
      wr(SIP_DMA_MODE_OFF, 32'h00, SIP_RESP_OKAY);
   endtask
   task automatic t_prefetch;
      logic [3:0] evs[4] = '{4'b1010, 4'b1000, 4'b0110, 4'b0100};
      wr(SIP_DMA_MODE_OFF, 32'h40, SIP_RESP_OKAY);
      wr(SIP_DMA_CTRL_OFF, 32'h20, SIP_RESP_OKAY);
      fetch(32'h2_0000, SIP_K_PLAIN, 3'h2);
      ereq(32'h2_0000, 5'h04);
      fetch(32'h2_0008, SIP_K_PLAIN, 3'h2);
      enone();
      wr(SIP_DMA_MODE_OFF, 32'h80, SIP_RESP_OKAY);
      wr(SIP_INSTR_PTR_OFF, 32'h2_0000, SIP_RESP_OKAY);
      chk(ip_value, 32'h2_0000);
      rd(SIP_INSTR_PTR_OFF, 32'h2_0000, SIP_RESP_OKAY);
      fetch(32'h2_0000, SIP_K_PLAIN, 3'h1);
      ereq(32'h2_0000, 5'h08);
      fetch(32'h2_0010, SIP_K_PLAIN, 3'h2);
      enone();
      evp(4'b0001);
      fetch(32'h2_0004, SIP_K_PLAIN, 3'h1);
      ereq(32'h2_0004, 5'h08);
      // no-flush variants keep the buffer, plain ones refill it
      for (int i = 0; i < 4; i++) begin
         evp(evs[i]);
         fetch(32'h2_0008, SIP_K_PLAIN, 3'h1);
         if (i % 2 == 1) ereq(32'h2_0008, 5'h08);
         else enone();
      end
      wr(SIP_DMA_CTRL_OFF, 32'h60, SIP_RESP_OKAY);
      rd(SIP_DMA_CTRL_OFF, 32'h20, SIP_RESP_OKAY);
      fetch(32'h2_0008, SIP_K_PLAIN, 3'h1);
      ereq(32'h2_0008, 5'h08);
   endtask
   // two word burst code with prefetch on: prefetch must stand aside
   task automatic t_short;
      wr(SIP_DMA_MODE_OFF, 32'h00, SIP_RESP_OKAY);
      fetch(32'h3_0000, SIP_K_PLAIN, 3'h2);
      ereq(32'h3_0000, 5'h01);
      ereq(32'h3_0004, 5'h01);
      wr(SIP_DMA_CTRL_OFF, 32'h00, SIP_RESP_OKAY);
   endtask
   // ram fetches fill the word fifo while the engine stalls
   task automatic t_ram_fill;
      send(32'h200, SIP_K_PLAIN, 3'h4);
      send(32'h210, SIP_K_PLAIN, 3'h1);
      repeat (30) @(posedge aclk);
      chk({31'h0, ins_ready}, 32'h0);
      chk({31'h0, word_valid}, 32'h1);
      get(32'h200, 5);
      enone();
   endtask

   // watchdog well beyond the few hundred cycles the run needs
   initial begin
      #500000;
      failures++;
      end_sim();
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {ins_valid, word_ready, slow, ev, ins, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      failures = 0;
      n_compared = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_direct();
      t_bof();
      t_prefetch();
      t_short();
      t_ram_fill();
      end_sim();
   end
endmodule
